// file: hdl/ptmr_top.v
// Periodic 10-bit timer: registers, clock select, counter, compare, capture, output pin.
// Assumes one 10 MHz clock, synchronous high reset, and high and sub clock ticks as enables.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "ptmr_defines.vh"
module ptmr_top
#(
  parameter CW = 10
)
(
  input wire CLOCK_I, // 10 MHz system clock
  input wire SRST_I, // Synchronous reset, active high
  input wire [`PTMR_ADDR_W-1:0] ADDR_I, // Register index
  input wire [7:0] WDATA_I, // Write data
  input wire WR_I, // Write strobe
  input wire RD_I, // Read strobe
  output reg [7:0] RDATA_O, // Read data, cycle after strobe
  input wire HIGH_TICK_I, // High clock enable pulse
  input wire SUB_TICK_I, // Sub clock enable pulse
  input wire EXT_CLOCK_PIN_I, // External clock pin
  input wire CAPTURE_INPUT_PIN_I, // Capture input pin
  output reg TIMER_OUTPUT_PIN_O // Timer output pin
);
  reg [7:0] ctrl0_reg;
  reg [7:0] ctrl1_reg;
  reg [1:0] capclr_reg;
  reg latch_edge_reg;
  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] cmpa_reg;
  reg [CW-1:0] cmpb_reg;
  reg [CW-1:0] per_reg;
  reg run_last_reg;
  reg out_reg;
  reg [1:0] div4_reg;
  reg [5:0] hdiv_reg;
  reg tick;
  reg [7:0] rd_next;
  wire ext_rise;
  wire ext_fall;
  wire cap_rise;
  wire cap_fall;
  wire counter_hold = ctrl0_reg[`PTMR_HOLD_BIT];
  wire [2:0] count_clock_select = ctrl0_reg[`PTMR_CKSEL_HI:`PTMR_CKSEL_LO];
  wire timer_run = ctrl0_reg[`PTMR_RUN_BIT];
  wire [1:0] operating_mode_select = ctrl1_reg[`PTMR_MODE_HI:`PTMR_MODE_LO];
  wire [1:0] pin_function_select = ctrl1_reg[`PTMR_PFS_HI:`PTMR_PFS_LO];
  wire output_initial_level = ctrl1_reg[`PTMR_OIL_BIT];
  wire output_invert = ctrl1_reg[`PTMR_INV_BIT];
  wire capture_source_select = ctrl1_reg[`PTMR_CAPSRC_BIT];
  wire clear_source_select = ctrl1_reg[`PTMR_CLRSRC_BIT];
  wire run_rise = timer_run & ~run_last_reg;
  wire counting = timer_run & ~counter_hold & ~run_rise;
  wire mode_cap = (operating_mode_select == `PTMR_MODE_CAP);
  wire mode_pwm = (operating_mode_select == `PTMR_MODE_PWM);
  wire mode_tmr = (operating_mode_select == `PTMR_MODE_TMR);
  wire match_a = counting & tick & (cnt_reg == cmpa_reg);
  wire match_p = counting & tick & (cnt_reg == per_reg);
  wire overflow = counting & tick & (&cnt_reg);
  wire trig_rise = capture_source_select ? ext_rise : cap_rise;
  wire trig_fall = capture_source_select ? ext_fall : cap_fall;
  wire cap_on = mode_cap & timer_run & (pin_function_select != 2'h3);
  wire take_rise = cap_on & trig_rise & (pin_function_select != 2'h1);
  wire take_fall = cap_on & trig_fall & (pin_function_select != 2'h0);
  wire route_b = (capclr_reg != 2'h0);
  wire edge_clr = mode_cap & timer_run & ((capclr_reg[0] & trig_rise) | (capclr_reg[1] & trig_fall));
  reg do_clear;

  ptmr_edge u_ext
  (
    .clk_i(CLOCK_I),
    .srst_i(SRST_I),
    .pin_i(EXT_CLOCK_PIN_I),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  ptmr_edge u_cap
  (
    .clk_i(CLOCK_I),
    .srst_i(SRST_I),
    .pin_i(CAPTURE_INPUT_PIN_I),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  // Prescalers for the divided sources
  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      div4_reg <= 2'h0;
      hdiv_reg <= 6'h00;
    end
    else
    begin
      div4_reg <= div4_reg + 2'h1;
      if (HIGH_TICK_I)
        hdiv_reg <= hdiv_reg + 6'h01;
    end
  end

  always @*
  begin
    case (count_clock_select)
      `PTMR_CK_SYS4: tick = (div4_reg == 2'h3);
      `PTMR_CK_SYS: tick = 1'b1;
      `PTMR_CK_HI16: tick = HIGH_TICK_I & (hdiv_reg[3:0] == 4'hF);
      `PTMR_CK_HI64: tick = HIGH_TICK_I & (hdiv_reg == 6'h3F);
      `PTMR_CK_SUB0: tick = SUB_TICK_I;
      `PTMR_CK_SUB1: tick = SUB_TICK_I;
      `PTMR_CK_EXTR: tick = ext_rise;
      `PTMR_CK_EXTF: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // Clear source decision
  always @*
  begin
    do_clear = 1'b0;
    // Zero period means the full 10-bit range, so overflow clears unless compare A is the clear source
    if (mode_cap)
      do_clear = (per_reg == {CW{1'b0}}) ? overflow : match_p;
    else if (mode_pwm)
      do_clear = (per_reg == {CW{1'b0}}) ? overflow : match_p;
    else if (clear_source_select)
      do_clear = match_a;
    else
      do_clear = (per_reg == {CW{1'b0}}) ? overflow : match_p;
  end

  // Counter, run edge and capture edge clears
  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      cnt_reg <= {CW{1'b0}};
      run_last_reg <= 1'b0;
    end
    else
    begin
      run_last_reg <= timer_run;
      if (run_rise)
        cnt_reg <= {CW{1'b0}};
      else if (edge_clr)
        cnt_reg <= {CW{1'b0}};
      else if (counting & tick)
        cnt_reg <= do_clear ? {CW{1'b0}} : cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Register writes and capture latching
  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      ctrl0_reg <= `PTMR_CTRL_RST;
      ctrl1_reg <= `PTMR_CTRL_RST;
      capclr_reg <= 2'h0;
      latch_edge_reg <= 1'b0;
      cmpa_reg <= {CW{1'b0}};
      cmpb_reg <= {CW{1'b0}};
      per_reg <= {CW{1'b0}};
    end
    else
    begin
      if (WR_I)
      begin
        case (ADDR_I)
          `PTMR_OFF_CTRL0: ctrl0_reg <= {WDATA_I[7:3], 3'h0};
          `PTMR_OFF_CTRL1: ctrl1_reg <= WDATA_I;
          `PTMR_OFF_CTRL2: capclr_reg <= WDATA_I[2:1];
          `PTMR_OFF_CMPAL: cmpa_reg[7:0] <= WDATA_I;
          `PTMR_OFF_CMPAH: cmpa_reg[CW-1:8] <= WDATA_I[CW-9:0];
          `PTMR_OFF_CMPBL: cmpb_reg[7:0] <= WDATA_I;
          `PTMR_OFF_CMPBH: cmpb_reg[CW-1:8] <= WDATA_I[CW-9:0];
          `PTMR_OFF_PERL: per_reg[7:0] <= WDATA_I;
          `PTMR_OFF_PERH: per_reg[CW-1:8] <= WDATA_I[CW-9:0];
          default: ;
        endcase
      end
      if (take_rise & route_b)
        cmpb_reg <= cnt_reg;
      else if (take_rise)
        cmpa_reg <= cnt_reg;
      if (take_fall)
        cmpa_reg <= cnt_reg;
      if (take_rise)
        latch_edge_reg <= 1'b1;
      else if (take_fall)
        latch_edge_reg <= 1'b0;
    end
  end

  // Output level logic
  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
      out_reg <= 1'b0;
    else if (run_rise)
      out_reg <= output_initial_level;
    else if (operating_mode_select == `PTMR_MODE_CMP && match_a)
    begin
      case (pin_function_select)
        2'h1: out_reg <= 1'b0;
        2'h2: out_reg <= 1'b1;
        2'h3: out_reg <= ~out_reg;
        default: out_reg <= out_reg;
      endcase
    end
    else if (mode_pwm)
    begin
      case (pin_function_select)
        2'h0: out_reg <= ~output_initial_level;
        2'h1: out_reg <= output_initial_level;
        2'h2: out_reg <= (timer_run && cnt_reg < cmpa_reg) ? output_initial_level : ~output_initial_level;
        2'h3: out_reg <= (timer_run && !match_a) ? out_reg : ~output_initial_level;
        default: out_reg <= out_reg;
      endcase
    end
  end

  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
      TIMER_OUTPUT_PIN_O <= 1'b0;
    else if (mode_tmr | mode_cap)
      TIMER_OUTPUT_PIN_O <= 1'b0;
    else
      TIMER_OUTPUT_PIN_O <= out_reg ^ output_invert;
  end

  always @*
  begin
    case (ADDR_I)
      `PTMR_OFF_CTRL0: rd_next = ctrl0_reg;
      `PTMR_OFF_CTRL1: rd_next = ctrl1_reg;
      `PTMR_OFF_CTRL2: rd_next = {5'h00, capclr_reg, latch_edge_reg};
      `PTMR_OFF_CNTL: rd_next = cnt_reg[7:0];
      `PTMR_OFF_CNTH: rd_next = {6'h00, cnt_reg[CW-1:8]};
      `PTMR_OFF_CMPAL: rd_next = cmpa_reg[7:0];
      `PTMR_OFF_CMPAH: rd_next = {6'h00, cmpa_reg[CW-1:8]};
      `PTMR_OFF_CMPBL: rd_next = cmpb_reg[7:0];
      `PTMR_OFF_CMPBH: rd_next = {6'h00, cmpb_reg[CW-1:8]};
      `PTMR_OFF_PERL: rd_next = per_reg[7:0];
      `PTMR_OFF_PERH: rd_next = {6'h00, per_reg[CW-1:8]};
      default: rd_next = 8'h00;
    endcase
  end

  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
      RDATA_O <= 8'h00;
    else if (RD_I)
      RDATA_O <= rd_next;
    else
      RDATA_O <= 8'h00;
  end
endmodule

// file: hdl/ptmr_defines.vh
// Register map, field positions and reset values of the periodic timer.
// Assumes the including file owns the clock and reset.
`ifndef PTMR_DEFINES_VH
`define PTMR_DEFINES_VH
`define PTMR_ADDR_W 4
`define PTMR_OFF_CTRL0 4'h0
`define PTMR_OFF_CTRL1 4'h1
`define PTMR_OFF_CTRL2 4'h2
`define PTMR_OFF_CNTL 4'h3
`define PTMR_OFF_CNTH 4'h4
`define PTMR_OFF_CMPAL 4'h5
`define PTMR_OFF_CMPAH 4'h6
`define PTMR_OFF_CMPBL 4'h7
`define PTMR_OFF_CMPBH 4'h8
`define PTMR_OFF_PERL 4'h9
`define PTMR_OFF_PERH 4'hA
`define PTMR_CTRL_RST 8'h00
`define PTMR_HOLD_BIT 7
`define PTMR_CKSEL_HI 6
`define PTMR_CKSEL_LO 4
`define PTMR_RUN_BIT 3
`define PTMR_MODE_HI 7
`define PTMR_MODE_LO 6
`define PTMR_PFS_HI 5
`define PTMR_PFS_LO 4
`define PTMR_OIL_BIT 3
`define PTMR_INV_BIT 2
`define PTMR_CAPSRC_BIT 1
`define PTMR_CLRSRC_BIT 0
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_CAP 2'h1
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TMR 2'h3
`define PTMR_CK_SYS4 3'h0
`define PTMR_CK_SYS 3'h1
`define PTMR_CK_HI16 3'h2
`define PTMR_CK_HI64 3'h3
`define PTMR_CK_SUB0 3'h4
`define PTMR_CK_SUB1 3'h5
`define PTMR_CK_EXTR 3'h6
`define PTMR_CK_EXTF 3'h7
`define PTMR_DIV_SYS 4
`define PTMR_DIV_HI16 16
`define PTMR_DIV_HI64 64
`endif

// file: hdl/ptmr_edge.v
// Two-flop synchroniser with rise and fall pulse detection.
// Assumes the input is a slow external pin level.
`timescale 1ns/1ps
module ptmr_edge
(
  input wire clk_i, // Clock
  input wire srst_i, // Synchronous reset
  input wire pin_i, // Raw pin level
  output reg rise_o, // Rising edge pulse
  output reg fall_o // Falling edge pulse
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise_o <= sync_reg & ~last_reg;
      fall_o <= ~sync_reg & last_reg;
    end
  end
endmodule

// file: tb/ptmr_chk_assertions.sv
// Checker: register readback, idle read data and output pin relations of the timer.
// Assumes it is bound to ptmr_top and sees only its ports.
`timescale 1ns/1ps
module ptmr_chk
#(
  parameter CW = 10
)
(
  input wire CLOCK_I, // Clock
  input wire SRST_I, // Reset
  input wire [3:0] ADDR_I, // Index
  input wire [7:0] WDATA_I, // Write data
  input wire WR_I, // Write strobe
  input wire RD_I, // Read strobe
  input wire [7:0] RDATA_O, // Read data
  input wire TIMER_OUTPUT_PIN_O // Pin
);
  reg [4:0] c0_reg;
  reg [7:0] c1_reg;
  wire frz = c0_reg[4] | ~c0_reg[0];
  wire mq = c1_reg[6];
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SRST_I);
  // Shadow copies of control registers 0 and 1
  always @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      c0_reg <= 5'h00;
      c1_reg <= 8'h00;
    end
    else if (WR_I && ADDR_I == 4'h0)
      c0_reg <= WDATA_I[7:3];
    else if (WR_I && ADDR_I == 4'h1)
      c1_reg <= WDATA_I;
  end
  a_read_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data not zero");
  a_unmapped_zero: assert property (RD_I && ADDR_I > 4'hA |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl0_back: assert property (RD_I && ADDR_I == 4'h0 |=> RDATA_O == {$past(c0_reg), 3'h0})
    else $error("control 0 readback");
  a_ctrl1_back: assert property (RD_I && ADDR_I == 4'h1 |=> RDATA_O == $past(c1_reg))
    else $error("control 1 readback");
  a_high_bytes: assert property (RD_I && (ADDR_I == 4'h4 || ADDR_I == 4'h6 || ADDR_I == 4'h8 ||
    ADDR_I == 4'hA) |=> RDATA_O[7:2] == 6'h00) else $error("high byte upper bits");
  a_count_frozen: assert property (frz && RD_I && ADDR_I == 4'h3 ##2 frz && RD_I && ADDR_I == 4'h3
    |=> RDATA_O == $past(RDATA_O, 2)) else $error("count moved while held");
  a_run_level: assert property (WR_I && ADDR_I == 4'h0 && WDATA_I[3] && !c0_reg[0] && c1_reg[7:6] == 2'h0
    |-> ##3 TIMER_OUTPUT_PIN_O == (c1_reg[3] ^ c1_reg[2])) else $error("pin not at start level");
  a_timer_pin: assert property (mq && $past(mq) |-> !TIMER_OUTPUT_PIN_O)
    else $error("pin driven in timer mode");
  c_frozen_read: cover property (frz && RD_I && ADDR_I == 4'h3);
  c_pin_high: cover property (TIMER_OUTPUT_PIN_O && c1_reg[7:6] == 2'h0);
  c_run_write: cover property (WR_I && ADDR_I == 4'h0 && WDATA_I[3]);
endmodule
bind ptmr_top ptmr_chk #(.CW(CW)) u_chk (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TIMER_OUTPUT_PIN_O(TIMER_OUTPUT_PIN_O));

// file: tb/ptmr_tb.sv
// Testbench for the periodic timer: register bus tasks and directed sequences.
// Assumes ptmr_top with a 10 MHz clock and the checker bound to it.
`timescale 1ns/1ps
module testbench;
  reg CLOCK_I = 1'b0;
  reg SRST_I = 1'b1;
  reg [3:0] ADDR_I = 4'h0;
  reg [7:0] WDATA_I = 8'h00;
  reg WR_I = 1'b0;
  reg RD_I = 1'b0;
  reg HIGH_TICK_I = 1'b0;
  reg SUB_TICK_I = 1'b0;
  reg EXT_CLOCK_PIN_I = 1'b0;
  reg CAPTURE_INPUT_PIN_I = 1'b0;
  wire [7:0] RDATA_O;
  wire TIMER_OUTPUT_PIN_O;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer i;
  reg eb;
  reg ea;
  ptmr_top #(.CW(10)) dut (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .HIGH_TICK_I(HIGH_TICK_I), .SUB_TICK_I(SUB_TICK_I),
    .EXT_CLOCK_PIN_I(EXT_CLOCK_PIN_I), .CAPTURE_INPUT_PIN_I(CAPTURE_INPUT_PIN_I),
    .TIMER_OUTPUT_PIN_O(TIMER_OUTPUT_PIN_O));
  initial
  begin
    forever #50 CLOCK_I = ~CLOCK_I;
  end
  task chk8(input string nm, input [7:0] e, input [7:0] s);
  begin
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task chk1(input e);
  begin
    #1;
    chk8("pin", {7'h00, e}, {7'h00, TIMER_OUTPUT_PIN_O});
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge CLOCK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [7:0] e);
  begin
    @(posedge CLOCK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1;
    chk8("rdata", e, RDATA_O);
  end
  endtask
  // Enable pulses on the sub clock, or on the high clock when hi is set
  task tk(input integer n, input hi);
  begin
    repeat (n)
    begin
      @(posedge CLOCK_I);
      SUB_TICK_I <= !hi;
      HIGH_TICK_I <= hi;
      @(posedge CLOCK_I);
      SUB_TICK_I <= 1'b0;
      HIGH_TICK_I <= 1'b0;
    end
    repeat (4) @(posedge CLOCK_I);
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    #2000000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial
  begin
    repeat (5) @(posedge CLOCK_I);
    SRST_I <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
      rd(i[3:0], 8'h00);
    for (i = 5; i < 11; i = i + 1)
    begin
      wr(i[3:0], 8'hFF);
      rd(i[3:0], i[0] ? 8'hFF : 8'h03);
    end
    wr(4'h3, 8'h55);
    rd(4'h3, 8'h00);
    wr(4'h0, 8'hF7);
    rd(4'h0, 8'hF0);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h06);
    wr(4'h2, 8'h00);
    // Windows of 40 system clocks with the hold bit low
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(4'h0, 8'h00);
      wr(4'h0, {1'b1, i[2:0], 4'h8});
      wr(4'h0, {1'b0, i[2:0], 4'h8});
      repeat (38) @(posedge CLOCK_I);
      wr(4'h0, {1'b1, i[2:0], 4'h8});
      rd(4'h3, i ? 8'h28 : 8'h0A);
    end
    for (i = 2; i < 8; i = i + 1)
    begin
      wr(4'h0, 8'h00);
      EXT_CLOCK_PIN_I <= 1'b0;
      repeat (6) @(posedge CLOCK_I);
      wr(4'h0, {1'b0, i[2:0], 4'h8});
      if (i < 6)
        tk(64, i < 4);
      else
        repeat (5)
        begin
          repeat (6) @(posedge CLOCK_I);
          EXT_CLOCK_PIN_I <= ~EXT_CLOCK_PIN_I;
        end
      repeat (8) @(posedge CLOCK_I);
      rd(4'h3, i == 2 ? 8'h04 : i == 3 ? 8'h01 : i < 6 ? 8'h40 : i == 6 ? 8'h03 : 8'h02);
    end
    wr(4'h0, 8'h00);
    wr(4'h0, 8'hC8);
    tk(3, 0);
    rd(4'h3, 8'h00);
    wr(4'h0, 8'h48);
    tk(5, 0);
    wr(4'h0, 8'h40);
    tk(2, 0);
    rd(4'h3, 8'h05);
    rd(4'h3, 8'h05);
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h00);
    // Index bits: mode, pin function, initial level, invert
    for (i = 0; i < 64; i = i + 1)
      if (i[5:4] != 2'h1)
      begin
        wr(4'h0, 8'h40);
        wr(4'h1, {i[5:0], 2'h0});
        wr(4'h0, 8'h48);
        repeat (3) @(posedge CLOCK_I);
        eb = i[5:4] == 2'h3 ? 1'b0 : ((i[5] && i[3:2] == 2'h0) ? ~i[1] : i[1]) ^ i[0];
        chk1(eb);
        tk(3, 0);
        ea = i[5] ? (i[3:2] == 2'h1 ? i[1] : ~i[1]) : i[3:2] == 2'h0 ? i[1] : i[3:2] == 2'h1 ? 1'b0 :
          i[3:2] == 2'h2 ? 1'b1 : ~i[1];
        chk1(i[5:4] == 2'h3 ? 1'b0 : ea ^ i[0]);
      end
    wr(4'hA, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(4'h0, 8'h40);
      wr(4'h9, i == 1 ? 8'h01 : 8'h00);
      wr(4'h1, i == 3 ? 8'hA1 : i == 0 ? 8'h01 : 8'h00);
      wr(4'h0, 8'h48);
      tk(3, 0);
      rd(4'h3, i == 0 ? 8'h00 : i == 1 ? 8'h01 : 8'h03);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(4'h0, 8'h40);
      wr(4'h5, 8'h02);
      wr(4'h7, 8'h02);
      wr(4'h2, i == 2 ? 8'h02 : 8'h00);
      wr(4'h1, i == 1 ? 8'h70 : i == 3 ? 8'h42 : 8'h40);
      wr(4'h0, 8'h48);
      tk(4, 0);
      if (i == 3)
        EXT_CLOCK_PIN_I <= 1'b1;
      else
        CAPTURE_INPUT_PIN_I <= 1'b1;
      repeat (6) @(posedge CLOCK_I);
      rd(i == 2 ? 4'h7 : 4'h5, i == 1 ? 8'h02 : 8'h04);
      rd(4'h3, i == 2 ? 8'h00 : 8'h04);
      rd(4'h2, i == 2 ? 8'h03 : 8'h01);
      EXT_CLOCK_PIN_I <= 1'b0;
      CAPTURE_INPUT_PIN_I <= 1'b0;
      repeat (6) @(posedge CLOCK_I);
    end
    give_verdict;
  end
endmodule
